// *** davo_core.sv ***
// Delta angle and delta speed outputs: sample timing, six integrators and the register read port.
`timescale 1ns/1ps
// What this block does
// - Speed: sum sample pairs, scale by 1/(2fs)
// - Span length is decimation setting plus one
// - Internal sample tick runs at 2000 SPS
// - Two 16-bit speed registers form 32 bits
// - Angle high word two's complement, range/2^15
// - Angle low register holds result bits 15..0
// - 16-bit codes saturate at 0x7fff, 0x8000
// - 32-bit codes saturate at 0x7fffffff, 0x80000000
// - Speed high word covers plus minus 400
// - Speed low word adds sixteen finer bits
// - Result is change between consecutive updates
// - Angle uses same trapezoid on gyro samples
// - Angle range fixed by model: 360/720/2160
module davo_core
  import davo_pkg::*;
#(
  parameter int SAMPLE_W    = 24,               // Width of each incoming sample.
  parameter int SAMPLE_DIV  = DAVO_SAMPLE_CYC,  // Clock cycles per internal sample.
  parameter int ANGLE_RANGE = DAVO_RANGE_A      // Full-scale delta angle of this model.
)
(
  input  wire logic                        ref_clk,             // Block clock, 40 MHz.
  input  wire logic                        rstn,                // Asynchronous reset, active low.
  input  wire logic signed [SAMPLE_W-1:0]  gyro_x,              // X rate sample.
  input  wire logic signed [SAMPLE_W-1:0]  gyro_y,              // Y rate sample.
  input  wire logic signed [SAMPLE_W-1:0]  gyro_z,              // Z rate sample.
  input  wire logic signed [SAMPLE_W-1:0]  accel_x,             // X acceleration sample.
  input  wire logic signed [SAMPLE_W-1:0]  accel_y,             // Y acceleration sample.
  input  wire logic signed [SAMPLE_W-1:0]  accel_z,             // Z acceleration sample.
  input  wire logic        [DAVO_DEC_W-1:0] decimation_setting, // Samples per output, minus one.
  input  wire logic                        rd_en,               // Register read strobe.
  input  wire logic        [6:0]           rd_addr,             // Register read address.
  output logic             [DAVO_WORD_W-1:0] rd_data_r,         // Registered read data.
  input  wire logic                        wr_en,               // Register write strobe.
  input  wire logic        [6:0]           wr_addr,             // Register write address.
  input  wire logic        [DAVO_WORD_W-1:0] wr_data,           // Register write data.
  output logic                             data_ready_pin,      // One-cycle pulse per new result.
  output logic             [DAVO_RES_W-1:0] sample_tick_count   // Internal samples since reset.
);

  localparam int DIV_W = $clog2(SAMPLE_DIV + 1);  // Width of the sample divider.
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_DIV - 1);  // Last divider count.
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;  // Divider restart value.

  logic [DIV_W-1:0]      div_r;         // Clock counter inside one sample period.
  logic [DIV_W-1:0]      div_nxt;       // Next divider value.
  logic                  tick;          // One pulse per internal sample.
  logic [DAVO_DEC_W-1:0] span_cnt_r;    // Samples already taken in the current span.
  logic [DAVO_DEC_W-1:0] span_cnt_nxt;  // Next span count.
  logic                  span_first;    // Current tick opens a span.
  logic                  span_last;     // Current tick closes a span.
  logic                  ready_r;       // Registered ready pulse.
  logic                  ready_nxt;     // Next ready pulse.
  logic [DAVO_RES_W-1:0] tick_cnt_r;    // Free-running sample counter.
  logic [DAVO_RES_W-1:0] tick_cnt_nxt;  // Next sample counter.
  logic [DAVO_WORD_W-1:0] rd_data_nxt;  // Next read data.
  logic signed [SAMPLE_W-1:0] samples [DAVO_CHAN_N];  // Channel inputs, angles first.
  logic [DAVO_RES_W-1:0] results [DAVO_CHAN_N];       // Channel results, angles first.

  assign samples[0] = gyro_x;
  assign samples[1] = gyro_y;
  assign samples[2] = gyro_z;
  assign samples[3] = accel_x;
  assign samples[4] = accel_y;
  assign samples[5] = accel_z;

  // Divide the clock down to the internal sample rate and frame the decimation span.
  always_comb
  begin
    tick         = (div_r == DIV_LAST);
    div_nxt      = tick ? DIV_ZERO : div_r + 1'b1;
    span_first   = (span_cnt_r == '0);
    // A setting lowered mid-span to or below the current span count closes the span on the next tick.
    span_last    = (span_cnt_r >= decimation_setting);
    span_cnt_nxt = span_cnt_r;
    tick_cnt_nxt = tick_cnt_r;
    if (tick)
    begin
      span_cnt_nxt = span_last ? '0 : span_cnt_r + 1'b1;
      tick_cnt_nxt = tick_cnt_r + 1'b1;
    end
    ready_nxt = tick && span_last;
  end

  // Register the timing state.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_r      <= '0;
      span_cnt_r <= '0;
      ready_r    <= 1'b0;
      tick_cnt_r <= '0;
    end
    else
    begin
      div_r      <= div_nxt;
      span_cnt_r <= span_cnt_nxt;
      ready_r    <= ready_nxt;
      tick_cnt_r <= tick_cnt_nxt;
    end
  end

  assign data_ready_pin    = ready_r;
  assign sample_tick_count = tick_cnt_r;

  // One integrator per channel; every channel closes its span on the same tick.
  generate
    for (genvar ch = 0; ch < DAVO_CHAN_N; ch++)
    begin : g_chan
      davo_trap_acc #(
        .SAMPLE_W (SAMPLE_W)
      ) u_acc (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .tick       (tick),
        .span_first (span_first),
        .span_last  (span_last),
        .sample_in  (samples[ch]),
        .result_r   (results[ch])
      );
    end
  endgenerate

  // Decode reads; address bit 0 picks the same register, writes never reach the results.
  always_comb
  begin
    rd_data_nxt = rd_data_r;
    if (rd_en)
    begin
      unique case ({rd_addr[6:1], 1'b0})
        DAVO_X_ANGLE_LOW:  rd_data_nxt = results[0][15:0];
        DAVO_X_ANGLE_HIGH: rd_data_nxt = results[0][31:16];
        DAVO_Y_ANGLE_LOW:  rd_data_nxt = results[1][15:0];
        DAVO_Y_ANGLE_HIGH: rd_data_nxt = results[1][31:16];
        DAVO_Z_ANGLE_LOW:  rd_data_nxt = results[2][15:0];
        DAVO_Z_ANGLE_HIGH: rd_data_nxt = results[2][31:16];
        DAVO_X_SPEED_LOW:  rd_data_nxt = results[3][15:0];
        DAVO_X_SPEED_HIGH: rd_data_nxt = results[3][31:16];
        DAVO_Y_SPEED_LOW:  rd_data_nxt = results[4][15:0];
        DAVO_Y_SPEED_HIGH: rd_data_nxt = results[4][31:16];
        DAVO_Z_SPEED_LOW:  rd_data_nxt = results[5][15:0];
        DAVO_Z_SPEED_HIGH: rd_data_nxt = results[5][31:16];
        default:           rd_data_nxt = DAVO_WORD_ZERO;
      endcase
    end
  end

  // Register the read data; write strobes have no path here.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_data_r <= '0;
    end
    else
    begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // The range parameter must name one of the model ranges.
  chk_angle_range: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ANGLE_RANGE == DAVO_RANGE_A) || (ANGLE_RANGE == DAVO_RANGE_B) || (ANGLE_RANGE == DAVO_RANGE_C))
    else $error("Angle range parameter is not a model range.");

  // At least four quiet cycles follow every sample tick, so the divider never fires early.
  chk_tick_spacing: assert property (@(posedge ref_clk) disable iff (!rstn)
    tick |=> !tick [*4])
    else $error("Sample ticks come too close together.");

  // The span counter wraps to zero after the closing tick.
  chk_span_wrap: assert property (@(posedge ref_clk) disable iff (!rstn)
    tick && span_last |=> span_cnt_r == '0)
    else $error("Span did not restart after its last sample.");

  // Ready follows every span close by one cycle and lasts one cycle.
  chk_ready_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
    tick && span_last |=> data_ready_pin ##1 !data_ready_pin)
    else $error("Ready pulse missing or too long.");

  // Results only move in the cycle where ready rises, both halves at once.
  chk_words_together: assert property (@(posedge ref_clk) disable iff (!rstn)
    (results[3] != $past(results[3])) |-> data_ready_pin)
    else $error("Speed result changed outside an update.");

  // The high speed word reads back bits 31..16 of the result.
  chk_read_high: assert property (@(posedge ref_clk) disable iff (!rstn)
    rd_en && (rd_addr == DAVO_X_SPEED_HIGH) && !ready_nxt |=> rd_data_r == results[3][31:16])
    else $error("Speed high word mismatch.");

  // The low angle word reads back bits 15..0 of the result.
  chk_read_low: assert property (@(posedge ref_clk) disable iff (!rstn)
    rd_en && (rd_addr == DAVO_Y_ANGLE_LOW) && !ready_nxt |=> rd_data_r == results[1][15:0])
    else $error("Angle low word mismatch.");

  // A write with no read leaves the read data unchanged.
  chk_write_ignored: assert property (@(posedge ref_clk) disable iff (!rstn)
    wr_en && !rd_en |=> rd_data_r == $past(rd_data_r))
    else $error("A write disturbed the read data.");

  // An unmapped read answers zero.
  chk_unmapped_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    rd_en && (rd_addr < DAVO_X_ANGLE_LOW) |=> rd_data_r == DAVO_WORD_ZERO)
    else $error("Unmapped read did not return zero.");

endmodule

// *** davo_pkg.sv ***
// Shared constants for the delta angle and delta velocity output block.
package davo_pkg;

  // Register offsets; each 16-bit register spans an even and the next odd address.
  localparam logic [6:0] DAVO_X_ANGLE_LOW  = 7'h24;  // X angle step, bits 15..0.
  localparam logic [6:0] DAVO_X_ANGLE_HIGH = 7'h26;  // X angle step, bits 31..16.
  localparam logic [6:0] DAVO_Y_ANGLE_LOW  = 7'h28;  // Y angle step, bits 15..0.
  localparam logic [6:0] DAVO_Y_ANGLE_HIGH = 7'h2a;  // Y angle step, bits 31..16.
  localparam logic [6:0] DAVO_Z_ANGLE_LOW  = 7'h2c;  // Z angle step, bits 15..0.
  localparam logic [6:0] DAVO_Z_ANGLE_HIGH = 7'h2e;  // Z angle step, bits 31..16.
  localparam logic [6:0] DAVO_X_SPEED_LOW  = 7'h30;  // X speed step, bits 15..0.
  localparam logic [6:0] DAVO_X_SPEED_HIGH = 7'h32;  // X speed step, bits 31..16.
  localparam logic [6:0] DAVO_Y_SPEED_LOW  = 7'h34;  // Y speed step, bits 15..0.
  localparam logic [6:0] DAVO_Y_SPEED_HIGH = 7'h36;  // Y speed step, bits 31..16.
  localparam logic [6:0] DAVO_Z_SPEED_LOW  = 7'h38;  // Z speed step, bits 15..0.
  localparam logic [6:0] DAVO_Z_SPEED_HIGH = 7'h3a;  // Z speed step, bits 31..16.

  // Result layout.
  localparam int DAVO_RES_W   = 32;  // Width of one delta result.
  localparam int DAVO_WORD_W  = 16;  // Width of one register.
  localparam int DAVO_CHAN_N  = 6;   // Three angle channels then three speed channels.
  localparam int DAVO_DEC_W   = 16;  // Width of the decimation setting.

  // Saturation codes of the 32-bit result, and the answer to an unmapped read.
  localparam logic [31:0] DAVO_RES_MAX = 32'h7fffffff;  // Largest positive result.
  localparam logic [31:0] DAVO_RES_MIN = 32'h80000000;  // Negative full scale.
  localparam logic [15:0] DAVO_WORD_ZERO = 16'h0000;    // Answer to an unmapped read.

  // Sample timing.
  localparam int DAVO_CLK_HZ     = 40_000_000;  // Rate of ref_clk in hertz.
  localparam int DAVO_SAMPLE_SPS = 2000;        // Nominal internal sample rate.
  localparam int DAVO_SAMPLE_CYC = DAVO_CLK_HZ / DAVO_SAMPLE_SPS;  // Clock cycles per sample.

  // Selectable full-scale delta angle ranges in degrees.
  localparam int DAVO_RANGE_A = 360;   // Lowest range model.
  localparam int DAVO_RANGE_B = 720;   // Middle range model.
  localparam int DAVO_RANGE_C = 2160;  // Highest range model.

  // Full-scale delta speed in metres per second.
  localparam int DAVO_SPEED_RANGE = 400;

endpackage

// *** davo_trap_acc.sv ***
// One channel of trapezoidal accumulation with a saturated 32-bit result.
`timescale 1ns/1ps
module davo_trap_acc
  import davo_pkg::*;
#(
  parameter int SAMPLE_W = 24,                    // Width of one signed sample.
  parameter int ACC_W    = SAMPLE_W + DAVO_DEC_W + 2  // Room for a full span of sums.
)
(
  input  wire logic                       ref_clk,     // Block clock.
  input  wire logic                       rstn,        // Asynchronous reset, active low.
  input  wire logic                       tick,        // One pulse per sample period.
  input  wire logic                       span_first,  // This tick opens a new span.
  input  wire logic                       span_last,   // This tick closes the span.
  input  wire logic signed [SAMPLE_W-1:0] sample_in,   // Current sample, already scaled by 1/fs.
  output logic             [DAVO_RES_W-1:0] result_r   // Latest completed delta result.
);

  logic signed [SAMPLE_W-1:0] prev_r;      // Previous sample, carried across spans.
  logic signed [SAMPLE_W-1:0] prev_nxt;    // Next previous sample.
  logic signed [ACC_W-1:0]    acc_r;       // Running sum of the span.
  logic signed [ACC_W-1:0]    acc_nxt;     // Next running sum.
  logic        [DAVO_RES_W-1:0] result_nxt;  // Next result.
  logic signed [ACC_W-1:0]    term;        // Current sample plus its predecessor.
  logic signed [ACC_W-1:0]    half;        // Span sum halved.

  // Add each sample to its predecessor, sum over the span, halve and saturate at the end.
  always_comb
  begin
    term     = ACC_W'(sample_in) + ACC_W'(prev_r);
    prev_nxt = prev_r;
    acc_nxt  = acc_r;
    result_nxt = result_r;
    if (tick)
    begin
      prev_nxt = sample_in;
      // A new span restarts the sum; the predecessor still comes from the last span.
      acc_nxt  = span_first ? term : acc_r + term;
    end
    half = acc_nxt >>> 1;
    // Clip to the 32-bit code range so overflow never wraps through zero.
    if (half > $signed(ACC_W'(DAVO_RES_MAX)))
    begin
      half = $signed(ACC_W'(DAVO_RES_MAX));
    end
    else if (half < -$signed(ACC_W'(DAVO_RES_MAX)) - 1)
    begin
      half = -$signed(ACC_W'(DAVO_RES_MAX)) - 1;
    end
    if (tick && span_last)
    begin
      result_nxt = half[DAVO_RES_W-1:0];
    end
  end

  // Register the channel state.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prev_r   <= '0;
      acc_r    <= '0;
      result_r <= '0;
    end
    else
    begin
      prev_r   <= prev_nxt;
      acc_r    <= acc_nxt;
      result_r <= result_nxt;
    end
  end

endmodule

// *** davo_host_model.sv ***
// Host-side model that times data-ready pulses to measure the real output rate.
`timescale 1ns/1ps
module davo_host_model
  import davo_pkg::*;
(
  input  wire logic                  ref_clk,         // Block clock.
  input  wire logic                  rstn,            // Asynchronous reset, active low.
  input  wire logic                  data_ready_pin,  // One-cycle pulse per new result.
  output logic [DAVO_RES_W-1:0]      period_r         // Cycles between the last two pulses.
);
  logic [DAVO_RES_W-1:0] gap_r;       // Cycles since the last pulse.
  logic [DAVO_RES_W-1:0] gap_nxt;     // Next value of the gap counter.
  logic [DAVO_RES_W-1:0] period_nxt;  // Next value of the measured period.

  // The host times the pulse spacing at any decimation setting to learn the true rate for rescaling.
  always_comb
  begin
    gap_nxt    = data_ready_pin ? '0 : gap_r + 32'h00000001;
    period_nxt = data_ready_pin ? gap_r + 32'h00000001 : period_r;
  end

  // Registers the counters; reset clears both so no stale period is seen.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gap_r    <= '0;
      period_r <= '0;
    end
    else
    begin
      gap_r    <= gap_nxt;
      period_r <= period_nxt;
    end
  end
endmodule

// *** delta_angle_velocity_outputs_bench.sv ***
// Self-checking testbench for the delta angle and delta speed output block.
`timescale 1ns/1ps
module delta_angle_velocity_outputs_bench;
  import davo_pkg::*;
  localparam int SW  = 32;  // Wide samples make saturation reachable in a short run.
  localparam int DIV = 8;   // Short sample period keeps the run brief.
  logic                    ref_clk, rstn, rd_en, wr_en, data_ready_pin;
  logic signed [SW-1:0]    gyro_x, gyro_y, gyro_z, accel_x, accel_y, accel_z;
  logic [DAVO_DEC_W-1:0]   decimation_setting;
  logic [6:0]              rd_addr, wr_addr;
  logic [DAVO_WORD_W-1:0]  wr_data, rd_data_r;
  logic [DAVO_RES_W-1:0]   sample_tick_count, t1, period_r;
  int                      fails, checks, i;
  longint                  smp [6];  // Samples of the six channels: three angle, three speed.

  // Free-running 40 MHz clock.
  always #12.5 ref_clk = ~ref_clk;

  davo_core #(.SAMPLE_W(SW), .SAMPLE_DIV(DIV)) uut (.ref_clk(ref_clk), .rstn(rstn), .gyro_x(gyro_x),
    .gyro_y(gyro_y), .gyro_z(gyro_z), .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z),
    .decimation_setting(decimation_setting), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data_r(rd_data_r),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .data_ready_pin(data_ready_pin),
    .sample_tick_count(sample_tick_count));
  davo_host_model host (.ref_clk(ref_clk), .rstn(rstn), .data_ready_pin(data_ready_pin), .period_r(period_r));

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Compares one register word.
  task automatic check16(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // Compares one 32-bit count.
  task automatic check32(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // One read: strobe for one edge, data is looked at in the following cycle.
  task automatic rd16(input logic [6:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    rd_en   <= 1'b1;
    rd_addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(negedge ref_clk);
    check16($sformatf("reg_%h", a), e, rd_data_r);
  endtask

  // One write, which the block must ignore.
  task automatic wr16(input logic [6:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    wr_en   <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  // Reads low then high word of a channel; the low word sits four bytes per channel above 0x24.
  task automatic rd_chan(input int c, input logic [31:0] e);
    rd16(7'h24 + 7'(4 * c), e[15:0]);
    rd16(7'h26 + 7'(4 * c), e[31:16]);
  endtask

  // Waits for n data-ready pulses under a bounded count.
  task automatic wait_ready(input int n);
    int k;
    k = 0;
    repeat (n)
      do
      begin
        @(negedge ref_clk);
        k++;
      end while (data_ready_pin !== 1'b1 && k < 400);
    if (k >= 400)
    begin
      fails++;
      $display("mismatch data_ready_pin expected pulse seen none");
    end
  endtask

  // Drives the decimation setting and all six samples on one edge.
  task automatic apply(input logic [15:0] d);
    @(posedge ref_clk);
    decimation_setting <= d;
    gyro_x  <= smp[0][SW-1:0];
    gyro_y  <= smp[1][SW-1:0];
    gyro_z  <= smp[2][SW-1:0];
    accel_x <= smp[3][SW-1:0];
    accel_y <= smp[4][SW-1:0];
    accel_z <= smp[5][SW-1:0];
  endtask

  // Expected result: half the sum of terms, floored, saturated to 32 bits.
  function automatic logic [31:0] exp_res(input longint s);
    longint h;
    h = s >>> 1;
    if (h > 64'sh000000007fffffff)
      return 32'h7fffffff;
    if (h < 64'shffffffff80000000)
      return 32'h80000000;
    return h[31:0];
  endfunction

  // Cuts a hang short; the full sequence needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    $display("mismatch watchdog expected finish seen timeout");
    close_out();
  end

  // Main sequence.
  initial
  begin
    {ref_clk, rstn, rd_en, wr_en, rd_addr, wr_addr, wr_data} = '0;
    {gyro_x, gyro_y, gyro_z, accel_x, accel_y, accel_z, decimation_setting} = '0;
    fails = 0;
    checks = 0;
    smp = '{100, -7, 3000000, -123456, 1, 65539};
    apply(16'h000f);
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    for (i = 0; i < 6; i++)
      rd_chan(i, 32'h00000000);
    rd16(7'h27, 16'h0000);
    wr16(7'h26, 16'hbeef);
    rd16(7'h26, 16'h0000);
    rd16(7'h40, DAVO_WORD_ZERO);
    // An address below the result map must also answer zero.
    rd16(7'h10, DAVO_WORD_ZERO);
    // First span starts with a zero predecessor, so its first term is the sample alone.
    wait_ready(1);
    t1 = sample_tick_count;
    for (i = 0; i < 6; i++)
      rd_chan(i, exp_res(31 * smp[i]));
    wait_ready(1);
    // The host model registers the period one cycle after the pulse.
    @(negedge ref_clk);
    check32("sample_tick_count", t1 + 32'h00000010, sample_tick_count);
    check32("period_r", 32'h00000080, period_r);
    for (i = 0; i < 6; i++)
      rd_chan(i, exp_res(32 * smp[i]));
    // Full-scale samples drive both saturation codes.
    smp[0] = 64'sh000000007fffffff;
    smp[3] = 64'shffffffff80000000;
    apply(16'h0001);
    wait_ready(3);
    @(negedge ref_clk);
    check32("period_r", 32'h00000010, period_r);
    rd_chan(0, exp_res(4 * smp[0]));
    rd_chan(3, exp_res(4 * smp[3]));
    rd_chan(1, exp_res(4 * smp[1]));
    apply(16'h0000);
    wait_ready(3);
    @(negedge ref_clk);
    check32("period_r", 32'h00000008, period_r);
    rd_chan(1, exp_res(2 * smp[1]));
    close_out();
  end
endmodule
